/* File: shared/ssca_pkg.sv */
// Constants, types and decode helpers for the SPI command access block
package ssca_pkg;
	// ---------------------------------------------------------------
	// Register map (register index on the serial link)
	// ---------------------------------------------------------------
	localparam logic [5:0] REG_TRX_CTRL_ONE = 6'h04;
	localparam logic [5:0] REG_TRX_STATE = 6'h01;
	localparam logic [5:0] REG_SIGNAL_STRENGTH = 6'h06;
	localparam logic [5:0] REG_IRQ_STATUS = 6'h0F;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h20;

	// ---------------------------------------------------------------
	// Field positions inside transceiver_control_one
	// ---------------------------------------------------------------
	localparam int CTRL_EXT_AMP_BIT = 7;
	localparam int CTRL_RX_START_PIN_BIT = 6;
	localparam int CTRL_AUTO_CRC_BIT = 5;
	localparam int CTRL_BUF_EMPTY_PIN_BIT = 4;
	localparam int CTRL_PFX_SEL_HI = 3;
	localparam int CTRL_PFX_SEL_LO = 2;
	localparam int CTRL_IRQ_MASK_MODE_BIT = 1;
	localparam int CTRL_IRQ_POLARITY_BIT = 0;

	// Status prefix select codes
	localparam logic [1:0] PFX_ZERO = 2'h0;
	localparam logic [1:0] PFX_STATE = 2'h1;
	localparam logic [1:0] PFX_RSSI = 2'h2;
	localparam logic [1:0] PFX_IRQ = 2'h3;

	// ---------------------------------------------------------------
	// Command byte decode, bits 7:5
	// ---------------------------------------------------------------
	localparam int CMD_REG_BIT = 7;
	localparam int CMD_WRITE_BIT = 6;
	localparam logic [2:0] CMD_SRAM_READ = 3'h0;
	localparam logic [2:0] CMD_FB_READ = 3'h1;
	localparam logic [2:0] CMD_SRAM_WRITE = 3'h2;
	localparam logic [2:0] CMD_FB_WRITE = 3'h3;

	// ---------------------------------------------------------------
	// Buffer space and frame limits
	// ---------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam logic [7:0] FB_LAST = 8'h7F;
	localparam logic [7:0] AES_FIRST = 8'h82;
	localparam logic [7:0] AES_LAST = 8'h94;
	localparam logic [6:0] MAX_FRAME_LEN = 7'h7F;
	localparam logic [7:0] FB_READ_MAX_BYTES = 8'h84;
	localparam logic [7:0] FB_WRITE_MAX_BYTES = 8'h81;
	localparam logic [7:0] TRAIL_BYTES = 8'h03;

	// Access mode of the open transaction
	typedef enum {
		SSCA_CMD,
		SSCA_REG_RD,
		SSCA_REG_WR,
		SSCA_FB_RD,
		SSCA_FB_WR,
		SSCA_SRAM_RA,
		SSCA_SRAM_WA,
		SSCA_SRAM_RD,
		SSCA_SRAM_WR,
		SSCA_DONE
	} ssca_mode_e;

	// True for an address that exists in the buffer space
	function automatic logic in_sram_space(input logic [7:0] addr);
		in_sram_space = (addr <= FB_LAST) || ((addr >= AES_FIRST) && (addr <= AES_LAST));
	endfunction : in_sram_space
endpackage : ssca_pkg

/* File: shared/ssca_mem_if.sv */
// Carrier between the link logic and the buffer memory
`timescale 1ns/100ps
`default_nettype none
interface ssca_mem_if;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;

	modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : ssca_mem_if
`default_nettype wire

/* File: design/ssca_sync.sv */
// Two-stage level synchroniser bank
`timescale 1ns/100ps
`default_nettype none
module ssca_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] hold_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else begin
			meta_ff <= d;
			hold_ff <= meta_ff;
		end
	end

	assign q = hold_ff;
endmodule : ssca_sync
`default_nettype wire

/* File: design/ssca_buffer_mem.sv */
// Frame buffer and cipher space memory, registered read
`timescale 1ns/100ps
`default_nettype none
module ssca_buffer_mem (
	input wire logic clk,
	ssca_mem_if.mem port
);
	logic [ssca_pkg::DATA_W-1:0] mem_array [ssca_pkg::MEM_DEPTH];
	logic [ssca_pkg::DATA_W-1:0] rd_data_ff;

	// Write then registered read, read-before-write on a clash
	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem_array[port.wr_addr] <= port.wr_data;
		end
		rd_data_ff <= mem_array[port.rd_addr];
	end

	assign port.rd_data = rd_data_ff;
endmodule : ssca_buffer_mem
`default_nettype wire

/* File: design/ssca_top.sv */
// SPI slave command decoder with register, frame buffer and SRAM access
`timescale 1ns/100ps
`default_nettype none
module ssca_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe_n,
	input wire logic [7:0] transceiver_state_reg,
	input wire logic [7:0] signal_strength_reg,
	input wire logic [7:0] irq_status_reg,
	input wire logic [7:0] link_quality,
	input wire logic [7:0] energy_level,
	input wire logic [7:0] rx_status_byte,
	output logic external_amp_enable,
	output logic rx_start_pin_enable,
	output logic tx_auto_crc_enable,
	output logic buffer_empty_pin_enable,
	output logic irq_mask_mode,
	output logic irq_polarity,
	output logic buffer_access_violation_irq
);
	// ---------------------------------------------------------------
	// Link domain declarations
	// ---------------------------------------------------------------
	logic link_rst;
	logic [2:0] bit_cnt_ff;
	logic [2:0] nxt_bit_cnt;
	logic [6:0] shift_ff;
	logic [6:0] nxt_shift;
	logic [7:0] byte_cnt_ff;
	logic [7:0] nxt_byte_cnt;
	ssca_pkg::ssca_mode_e mode_ff;
	ssca_pkg::ssca_mode_e nxt_mode;
	logic [7:0] addr_ff;
	logic [7:0] nxt_addr;
	logic [6:0] len_ff;
	logic [6:0] nxt_len;
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic viol_tgl_ff;
	logic nxt_viol_tgl;
	logic ctrl_tgl_ff;
	logic nxt_ctrl_tgl;
	logic [7:0] rx_byte;
	logic byte_done;
	logic ctrl_wr;
	logic viol;
	logic mem_wr;
	logic [7:0] load_byte;
	logic [7:0] prefix;
	logic [47:0] status_sync;
	logic first_ff;
	logic nxt_first;
	logic [2:0] pos_ff;
	logic [2:0] nxt_pos;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;

	// Clock domain declarations
	logic ctrl_tgl_sync;
	logic ctrl_seen_ff;
	logic [7:0] ctrl_sys_ff;
	logic viol_tgl_sync;
	logic viol_seen_ff;
	logic irq_pulse_ff;

	ssca_mem_if mem_bus ();

	// ---------------------------------------------------------------
	// Synchronisers and buffer memory
	// ---------------------------------------------------------------
	// Status inputs brought into the link domain
	ssca_sync #(
		.W(48)
	) u_status_sync (
		.clk(sclk),
		.rst(rst),
		.d({transceiver_state_reg, signal_strength_reg, irq_status_reg,
			link_quality, energy_level, rx_status_byte}),
		.q(status_sync)
	);

	// Control write toggle brought into the system domain
	ssca_sync #(
		.W(1)
	) u_ctrl_sync (
		.clk(clock),
		.rst(rst),
		.d(ctrl_tgl_ff),
		.q(ctrl_tgl_sync)
	);

	// Violation toggle brought into the system domain
	ssca_sync #(
		.W(1)
	) u_viol_sync (
		.clk(clock),
		.rst(rst),
		.d(viol_tgl_ff),
		.q(viol_tgl_sync)
	);

	ssca_buffer_mem u_mem (
		.clk(sclk),
		.port(mem_bus.mem)
	);

	// Select high ends the transaction and clears any partial byte
	assign link_rst = rst | sel_n;
	assign rx_byte = {shift_ff, mosi};
	assign byte_done = (bit_cnt_ff == 3'h7);

	// ---------------------------------------------------------------
	// Register read decode
	// ---------------------------------------------------------------
	function automatic logic [7:0] reg_read(input logic [5:0] idx, input logic [7:0] ctrl,
			input logic [47:0] st);
		case (idx)
			ssca_pkg::REG_TRX_CTRL_ONE: reg_read = ctrl;
			ssca_pkg::REG_TRX_STATE: reg_read = st[47:40];
			ssca_pkg::REG_SIGNAL_STRENGTH: reg_read = st[39:32];
			ssca_pkg::REG_IRQ_STATUS: reg_read = st[31:24];
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// ---------------------------------------------------------------
	// Command decode and byte sequencing (rising edge)
	// ---------------------------------------------------------------
	always_comb begin
		nxt_bit_cnt = bit_cnt_ff + 3'h1;
		nxt_shift = rx_byte[6:0];
		nxt_byte_cnt = byte_cnt_ff;
		nxt_mode = mode_ff;
		nxt_addr = addr_ff;
		nxt_len = len_ff;
		ctrl_wr = 1'b0;
		viol = 1'b0;
		mem_wr = 1'b0;
		if (byte_done) begin
			nxt_byte_cnt = (byte_cnt_ff == 8'hFF) ? byte_cnt_ff : byte_cnt_ff + 8'h01;
			case (mode_ff)
				ssca_pkg::SSCA_CMD: begin
					if (rx_byte[ssca_pkg::CMD_REG_BIT]) begin
						nxt_mode = rx_byte[ssca_pkg::CMD_WRITE_BIT] ? ssca_pkg::SSCA_REG_WR
							: ssca_pkg::SSCA_REG_RD;
						nxt_addr = {2'h0, rx_byte[5:0]};
					end else begin
						nxt_addr = 8'h00;
						case (rx_byte[7:5])
							ssca_pkg::CMD_FB_READ: nxt_mode = ssca_pkg::SSCA_FB_RD;
							ssca_pkg::CMD_FB_WRITE: nxt_mode = ssca_pkg::SSCA_FB_WR;
							ssca_pkg::CMD_SRAM_READ: nxt_mode = ssca_pkg::SSCA_SRAM_RA;
							ssca_pkg::CMD_SRAM_WRITE: nxt_mode = ssca_pkg::SSCA_SRAM_WA;
							default: nxt_mode = ssca_pkg::SSCA_DONE;
						endcase
					end
				end
				ssca_pkg::SSCA_REG_RD: begin
					nxt_mode = ssca_pkg::SSCA_DONE;
				end
				ssca_pkg::SSCA_REG_WR: begin
					ctrl_wr = (addr_ff[5:0] == ssca_pkg::REG_TRX_CTRL_ONE);
					nxt_mode = ssca_pkg::SSCA_DONE;
				end
				ssca_pkg::SSCA_FB_RD: begin
					if (addr_ff == 8'h00) begin
						nxt_len = rd_len(mem_bus.rd_data);
					end
					nxt_addr = addr_ff + 8'h01;
					viol = (byte_cnt_ff >= ssca_pkg::FB_READ_MAX_BYTES);
				end
				ssca_pkg::SSCA_FB_WR: begin
					if (byte_cnt_ff < ssca_pkg::FB_WRITE_MAX_BYTES) begin
						mem_wr = 1'b1;
						nxt_addr = addr_ff + 8'h01;
					end else begin
						viol = 1'b1;
					end
				end
				ssca_pkg::SSCA_SRAM_RA: begin
					nxt_addr = rx_byte;
					nxt_mode = ssca_pkg::SSCA_SRAM_RD;
				end
				ssca_pkg::SSCA_SRAM_WA: begin
					nxt_addr = rx_byte;
					nxt_mode = ssca_pkg::SSCA_SRAM_WR;
				end
				ssca_pkg::SSCA_SRAM_RD: begin
					nxt_addr = addr_ff + 8'h01;
				end
				ssca_pkg::SSCA_SRAM_WR: begin
					mem_wr = ssca_pkg::in_sram_space(addr_ff);
					nxt_addr = addr_ff + 8'h01;
				end
				default: nxt_mode = ssca_pkg::SSCA_DONE;
			endcase
		end
	end

	// Frame length field is seven bits, so never above the maximum
	function automatic logic [6:0] rd_len(input logic [7:0] phr);
		rd_len = (phr[6:0] > ssca_pkg::MAX_FRAME_LEN) ? ssca_pkg::MAX_FRAME_LEN : phr[6:0];
	endfunction : rd_len

	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_ff <= 3'h0;
			shift_ff <= 7'h00;
			byte_cnt_ff <= 8'h00;
			mode_ff <= ssca_pkg::SSCA_CMD;
			addr_ff <= 8'h00;
			len_ff <= 7'h00;
		end else begin
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			byte_cnt_ff <= nxt_byte_cnt;
			mode_ff <= nxt_mode;
			addr_ff <= nxt_addr;
			len_ff <= nxt_len;
		end
	end

	// Memory port: reads follow the next address so data is ready early
	assign mem_bus.rd_addr = nxt_addr;
	assign mem_bus.wr_en = mem_wr;
	assign mem_bus.wr_addr = addr_ff;
	assign mem_bus.wr_data = rx_byte;

	// ---------------------------------------------------------------
	// Control register and violation toggle (survive select)
	// ---------------------------------------------------------------
	always_comb begin
		nxt_ctrl = ctrl_wr ? rx_byte : ctrl_ff;
		nxt_ctrl_tgl = ctrl_wr ? ~ctrl_tgl_ff : ctrl_tgl_ff;
		nxt_viol_tgl = viol ? ~viol_tgl_ff : viol_tgl_ff;
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= ssca_pkg::CTRL_ONE_RESET;
			ctrl_tgl_ff <= 1'b0;
			viol_tgl_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			ctrl_tgl_ff <= nxt_ctrl_tgl;
			viol_tgl_ff <= nxt_viol_tgl;
		end
	end

	// ---------------------------------------------------------------
	// Outgoing byte selection
	// ---------------------------------------------------------------
	always_comb begin
		case (ctrl_ff[ssca_pkg::CTRL_PFX_SEL_HI:ssca_pkg::CTRL_PFX_SEL_LO])
			ssca_pkg::PFX_STATE: prefix = status_sync[47:40];
			ssca_pkg::PFX_RSSI: prefix = status_sync[39:32];
			ssca_pkg::PFX_IRQ: prefix = status_sync[31:24];
			default: prefix = 8'h00;
		endcase
	end

	// Next byte for MISO, chosen by the mode just entered
	always_comb begin
		case (mode_ff)
			ssca_pkg::SSCA_REG_RD: load_byte = reg_read(addr_ff[5:0], ctrl_ff, status_sync);
			ssca_pkg::SSCA_FB_RD: begin
				if ((addr_ff == 8'h00) || (addr_ff <= {1'b0, len_ff})) begin
					load_byte = mem_bus.rd_data;
				end else begin
					case (addr_ff - {1'b0, len_ff} - 8'h01)
						8'h00: load_byte = status_sync[23:16];
						8'h01: load_byte = status_sync[15:8];
						8'h02: load_byte = status_sync[7:0];
						default: load_byte = 8'h00;
					endcase
				end
			end
			ssca_pkg::SSCA_SRAM_RD: load_byte = mem_bus.rd_data;
			default: load_byte = 8'h00;
		endcase
	end

	// ---------------------------------------------------------------
	// MISO shifter (falling edge)
	// ---------------------------------------------------------------
	always_comb begin
		nxt_first = first_ff;
		nxt_pos = pos_ff;
		nxt_tx = {tx_ff[6:0], 1'b0};
		if ((bit_cnt_ff == 3'h0) && (byte_cnt_ff != 8'h00)) begin
			nxt_first = 1'b0;
			nxt_tx = load_byte;
		end else if (first_ff) begin
			nxt_pos = pos_ff + 3'h1;
		end
	end

	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			first_ff <= 1'b1;
			pos_ff <= 3'h0;
			tx_ff <= 8'h00;
		end else begin
			first_ff <= nxt_first;
			pos_ff <= nxt_pos;
			tx_ff <= nxt_tx;
		end
	end

	// Prefix bits go out during the first byte, later bytes from the shifter
	assign miso_o = first_ff ? prefix[3'h7 - pos_ff] : tx_ff[7];
	assign miso_oe_n = sel_n;

	// ---------------------------------------------------------------
	// System domain: control outputs and violation pulse
	// ---------------------------------------------------------------
	assign external_amp_enable = ctrl_sys_ff[ssca_pkg::CTRL_EXT_AMP_BIT];
	assign rx_start_pin_enable = ctrl_sys_ff[ssca_pkg::CTRL_RX_START_PIN_BIT];
	assign tx_auto_crc_enable = ctrl_sys_ff[ssca_pkg::CTRL_AUTO_CRC_BIT];
	assign buffer_empty_pin_enable = ctrl_sys_ff[ssca_pkg::CTRL_BUF_EMPTY_PIN_BIT];
	assign irq_mask_mode = ctrl_sys_ff[ssca_pkg::CTRL_IRQ_MASK_MODE_BIT];
	assign irq_polarity = ctrl_sys_ff[ssca_pkg::CTRL_IRQ_POLARITY_BIT];

	// Toggle edge becomes a one-cycle interrupt pulse
	// Control word copied whole once its write toggle has settled, so no torn word;
	// writes closer than about four system clocks may merge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_seen_ff <= 1'b0;
			ctrl_sys_ff <= ssca_pkg::CTRL_ONE_RESET;
			viol_seen_ff <= 1'b0;
			irq_pulse_ff <= 1'b0;
		end else begin
			ctrl_seen_ff <= ctrl_tgl_sync;
			ctrl_sys_ff <= (ctrl_tgl_sync ^ ctrl_seen_ff) ? ctrl_ff : ctrl_sys_ff;
			viol_seen_ff <= viol_tgl_sync;
			irq_pulse_ff <= viol_tgl_sync ^ viol_seen_ff;
		end
	end

	assign buffer_access_violation_irq = irq_pulse_ff;
endmodule : ssca_top
`default_nettype wire

/* File: verification/ssca_props.sv */
// Checker for the SPI command access block
`timescale 1ns/100ps
`default_nettype none
module ssca_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic miso_o,
	input wire logic miso_oe_n,
	input wire logic external_amp_enable,
	input wire logic rx_start_pin_enable,
	input wire logic tx_auto_crc_enable,
	input wire logic buffer_empty_pin_enable,
	input wire logic irq_mask_mode,
	input wire logic irq_polarity,
	input wire logic buffer_access_violation_irq
);
	logic [3:0] idle_ff;
	logic [3:0] nxt_idle;
	logic [5:0] ctrl;
	logic irq;
	// Control outputs as one vector
	assign ctrl = {external_amp_enable, rx_start_pin_enable, tx_auto_crc_enable,
		buffer_empty_pin_enable, irq_mask_mode, irq_polarity};
	assign irq = buffer_access_violation_irq;
	// Saturating count of idle select cycles
	always_comb begin
		nxt_idle = !sel_n ? 4'h0 : (idle_ff == 4'hF) ? idle_ff : idle_ff + 4'h1;
	end
	// Idle counter register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idle_ff <= 4'h0;
		end else begin
			idle_ff <= nxt_idle;
		end
	end
	// Control register leaves reset at its default
	sequence s_ctrl_rst;
		##2 (ctrl == 6'h08);
	endsequence
	// No violation pulse just after reset
	sequence s_irq_quiet;
		!irq [*4];
	endsequence
	AST_OE_CLK: assert property (@(posedge clock) disable iff (rst) miso_oe_n == sel_n)
		else $error("miso enable differs from select");
	AST_OE_SCLK: assert property (@(posedge sclk) disable iff (rst) !sel_n |-> !miso_oe_n)
		else $error("miso not driven inside frame");
	AST_IRQ_PULSE: assert property (@(posedge clock) disable iff (rst) irq |=> !irq)
		else $error("violation pulse longer than one cycle");
	AST_CTRL_IDLE: assert property (@(posedge clock) disable iff (rst) idle_ff >= 4'h6 |-> $stable(ctrl))
		else $error("control output moved while idle");
	AST_IRQ_IDLE: assert property (@(posedge clock) disable iff (rst) idle_ff >= 4'h8 |-> !irq)
		else $error("violation pulse without traffic");
	AST_CTRL_RST: assert property (@(posedge clock) disable iff (rst) $fell(rst) |-> s_ctrl_rst)
		else $error("control outputs wrong after reset");
	AST_MISO_IDLE: assert property (@(posedge clock) disable iff (rst) sel_n && $past(sel_n) |-> $stable(miso_o))
		else $error("miso moved while deselected");
	AST_IRQ_RST: assert property (@(posedge clock) disable iff (rst) $fell(rst) |-> s_irq_quiet)
		else $error("violation pulse after reset");
endmodule : ssca_props
bind ssca_top ssca_props chk_u (.clock(clock), .rst(rst), .sclk(sclk), .sel_n(sel_n),
	.miso_o(miso_o), .miso_oe_n(miso_oe_n), .external_amp_enable(external_amp_enable),
	.rx_start_pin_enable(rx_start_pin_enable), .tx_auto_crc_enable(tx_auto_crc_enable),
	.buffer_empty_pin_enable(buffer_empty_pin_enable), .irq_mask_mode(irq_mask_mode),
	.irq_polarity(irq_polarity), .buffer_access_violation_irq(buffer_access_violation_irq));
`default_nettype wire

/* File: verification/ssca_host_model.sv */
// Host side SPI master model
`timescale 1ns/100ps
`default_nettype none
module ssca_host_model (
	input wire logic clock,
	input wire logic miso,
	output logic sclk,
	output logic sel_n,
	output logic mosi
);
	int gap = 0;
	// Idle lines; select starts low so that reset's rise reaches the link state
	initial begin
		sclk = 1'b0;
		sel_n = 1'b0;
		mosi = 1'b0;
		#2;
		sel_n = 1'b1;
	end
	// Open a frame off the system clock
	task automatic open_frame();
		@(negedge clock);
		sel_n = 1'b0;
		#7;
	endtask : open_frame
	// Swap nb bits each way, MSB first, mode 0
	task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			mosi = tx[i];
			#6 sclk = 1'b1;
			rx[i] = miso;
			#6 sclk = 1'b0;
		end
		#(gap);
	endtask : shift
	// Release select; data line no longer holds its value
	task automatic close_frame();
		#6;
		@(negedge clock);
		sel_n = 1'b1;
		mosi = ~mosi;
		@(negedge clock);
	endtask : close_frame
endmodule : ssca_host_model
`default_nettype wire

/* File: verification/ssca_top_test.sv */
// Self-checking bench for the SPI command access block
`timescale 1ns/100ps
`default_nettype none
module ssca_top_test;
	logic clock = 1'b0;
	logic rst = 1'b0; // Raised at 1 ns so every async reset sees an edge
	logic sclk, sel_n, mosi, miso_o, miso_oe_n, miso_w, irq;
	logic miso_last = 1'b0;
	logic [5:0] ctrl_o;
	logic [7:0] sv [6] = '{8'h16, 8'h5A, 8'hC3, 8'hE1, 8'h3C, 8'h80};
	int mismatches = 0;
	int checks = 0;
	int irq_n = 0;
	ssca_top dut_u (.clock(clock), .rst(rst), .sclk(sclk), .sel_n(sel_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe_n(miso_oe_n), .transceiver_state_reg(sv[0]),
		.signal_strength_reg(sv[1]), .irq_status_reg(sv[2]), .link_quality(sv[3]),
		.energy_level(sv[4]), .rx_status_byte(sv[5]), .external_amp_enable(ctrl_o[5]),
		.rx_start_pin_enable(ctrl_o[4]), .tx_auto_crc_enable(ctrl_o[3]),
		.buffer_empty_pin_enable(ctrl_o[2]), .irq_mask_mode(ctrl_o[1]),
		.irq_polarity(ctrl_o[0]), .buffer_access_violation_irq(irq));
	ssca_host_model h_u (.clock(clock), .miso(miso_w), .sclk(sclk), .sel_n(sel_n), .mosi(mosi));
	// System clock
	initial begin
		forever #50 clock = ~clock;
	end
	// Released data line shows the inverse of its last level
	always @(miso_o or miso_oe_n) begin
		if (!miso_oe_n) miso_last = miso_o;
	end
	assign miso_w = miso_oe_n ? ~miso_last : miso_o;
	// Count violation pulses
	always @(posedge clock) begin
		if (irq === 1'b1) irq_n++;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// Command plus one data byte
	task automatic reg_acc(input logic [7:0] cmd, input logic [7:0] wd, input logic [7:0] pfx,
		input logic [7:0] exp);
		logic [7:0] rx;
		h_u.open_frame();
		h_u.shift(cmd, 8, rx);
		cmp(rx, pfx);
		h_u.shift(wd, 8, rx);
		if (!cmd[6]) cmp(rx, exp);
		h_u.close_frame();
	endtask : reg_acc
	// Byte sequence; XX marks a byte to be ignored
	task automatic seq(input logic [7:0] tx[$], input logic [7:0] ex[$]);
		logic [7:0] rx;
		h_u.open_frame();
		foreach (tx[i]) begin
			h_u.shift(tx[i], 8, rx);
			if (i < ex.size() && ex[i] !== 8'hXX) cmp(rx, ex[i]);
		end
		h_u.close_frame();
	endtask : seq
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// Watchdog
	initial begin
		#1000000;
		mismatches++;
		$display("ERROR %0t watchdog expired", $time);
		final_report();
	end
	// Main sequence
	initial begin
		logic [7:0] q[$];
		logic [7:0] p[4];
		logic [7:0] rx;
		logic [7:0] pv;
		#1;
		rst = 1'b1;
		repeat (12) @(negedge clock);
		rst = 1'b0;
		sv[0] = 8'h19;
		repeat (3) @(negedge clock);
		reg_acc(8'h84, 8'hFF, 8'h00, 8'h20);
		cmp({2'b00, ctrl_o}, 8'h08);
		reg_acc(8'hC4, 8'hD3, 8'h00, 8'h00);
		repeat (4) @(negedge clock);
		cmp({2'b00, ctrl_o}, 8'h37);
		reg_acc(8'h84, 8'h00, 8'h00, 8'hD3);
		reg_acc(8'hFF, 8'h5A, 8'h00, 8'h00);
		reg_acc(8'hBF, 8'hFF, 8'h00, 8'h00);
		p = '{8'h00, sv[0], sv[1], sv[2]};
		pv = 8'h00;
		for (int s = 0; s < 4; s++) begin
			reg_acc(8'hC4, {4'h0, 2'(s), 2'b00}, pv, 8'h00);
			q = '{8'h84, 8'h81, 8'h86, 8'h8F};
			pv = p[s];
			reg_acc(q[s], 8'hFF, pv, pv);
		end
		@(negedge clock);
		sv[3] = 8'h7E;
		sv[4] = 8'h42;
		sv[5] = 8'h9D;
		seq('{8'h7F, 8'h03, 8'hA1, 8'hB2, 8'hC3}, '{pv});
		q = '{8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		seq(q, '{pv, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'h7E, 8'h42, 8'h9D});
		seq('{8'h20, 8'h00}, '{pv, 8'h03});
		h_u.open_frame();
		h_u.shift(8'h20, 8, rx);
		h_u.shift(8'h00, 3, rx);
		h_u.close_frame();
		seq('{8'h20, 8'h00, 8'h00}, '{pv, 8'h03, 8'hA1});
		h_u.gap = 400;
		seq('{8'h40, 8'h7E, 8'h11, 8'h22}, '{pv});
		seq('{8'h5F, 8'h93, 8'h33, 8'h44}, '{pv});
		h_u.gap = 0;
		seq('{8'h00, 8'h7E, 8'h00, 8'h00}, '{pv, 8'hXX, 8'h11, 8'h22});
		seq('{8'h00, 8'h93, 8'h00, 8'h00}, '{pv, 8'hXX, 8'h33, 8'h44});
		seq('{8'h00, 8'h01, 8'h00, 8'h00}, '{pv, 8'hXX, 8'hA1, 8'hB2});
		repeat (8) @(negedge clock);
		cmp(8'(irq_n), 8'h00);
		for (int n = 132; n < 134; n++) begin
			q = '{8'h20};
			repeat (n - 1) q.push_back(8'h00);
			seq(q, '{pv});
			repeat (8) @(negedge clock);
			cmp(8'(irq_n), 8'(n - 132));
		end
		for (int n = 129; n < 131; n++) begin
			q = '{8'h60};
			repeat (n - 1) q.push_back(8'h00);
			seq(q, '{pv});
			repeat (8) @(negedge clock);
			cmp(8'(irq_n), 8'(n - 128));
		end
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		reg_acc(8'h84, 8'hFF, 8'h00, 8'h20);
		final_report();
	end
endmodule : ssca_top_test
`default_nettype wire
